// ===== core/rcp_pkg.sv
// Package with offsets, bit positions and reset values of the power-control registers
`default_nettype none
package rcp_pkg;
    localparam int RCP_AW = 12;
    localparam int RCP_DW = 8;

    localparam logic [11:0] RCP_OFS_BROWNOUT_CONTROL = 12'h811;
    localparam logic [11:0] RCP_OFS_RESET_CAUSE_FLAGS = 12'h813;
    localparam logic [11:0] RCP_OFS_MEMORY_VIOLATION_FLAGS = 12'h814;
    localparam logic [11:0] RCP_OFS_EVENT_STATUS = 12'h815;
    localparam logic [11:0] RCP_OFS_EVENT_MASK = 12'h816;

    // Brownout control fields
    localparam int RCP_BIT_SOFT_BOR_EN = 7;
    localparam int RCP_BIT_BOR_READY = 0;
    localparam logic [1:0] RCP_CFG_SOFT = 2'h1;
    localparam logic [1:0] RCP_CFG_OFF = 2'h0;

    // Reset cause flag positions
    localparam int RCP_BIT_STK_OVF = 7;
    localparam int RCP_BIT_STK_UNF = 6;
    localparam int RCP_BIT_WDT_WIN = 5;
    localparam int RCP_BIT_WDT_TO = 4;
    localparam int RCP_BIT_PIN_RST = 3;
    localparam int RCP_BIT_RST_INSTR = 2;
    localparam int RCP_BIT_POR = 1;
    localparam int RCP_BIT_BOR = 0;
    localparam int RCP_BIT_MEMORY_VIOLATION_FLAG = 1;

    // Event status positions
    localparam int RCP_EV_MEMORY_VIOLATION_FLAG = 0;
    localparam int RCP_EV_BOR = 1;
    localparam int RCP_EV_RST_INSTR = 2;
    localparam int RCP_EV_PIN_RST = 3;
    localparam int RCP_EV_WDT_TO = 4;
    localparam int RCP_EV_WDT_WIN = 5;
    localparam int RCP_EV_STK_UNF = 6;
    localparam int RCP_EV_STK_OVF = 7;

    // Values after reset
    localparam logic [7:0] RCP_RST_CAUSE_FLAGS = 8'h3C;
    localparam logic RCP_RST_MEMORY_VIOLATION_FLAG = 1'b1;
    localparam logic RCP_RST_SOFT_BOR_EN = 1'b1;
    localparam logic [7:0] RCP_RST_STATUS = 8'h00;
    localparam logic [7:0] RCP_RST_MASK = 8'h00;
    localparam logic [7:0] RCP_RST_RD_DATA = 8'h00;
endpackage
`default_nettype wire

// ===== core/rcp_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module rcp_sync2 (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== core/rcp_regs.sv
// Reset cause and brownout control register bank
// Behaviour
// - With the brownout config field at 01 the soft enable bit switches detection on or off.
// - The ready bit reads 1 only while the brownout circuit is enabled and reports armed.
// - A stack overflow sets its flag; power-on or brownout clears it; firmware may clear it.
// - A stack underflow sets its flag; power-on or brownout clears it; firmware may clear it.
// - A watchdog window violation reset clears its flag; power-on or brownout sets it.
// - A watchdog time-out reset clears its flag; power-on or brownout sets it.
// - An external pin reset clears its flag; power-on or brownout sets it.
// - A reset instruction clears its flag; power-on or brownout sets it.
// - Only a power-on reset or a firmware write clears the power-on flag.
// - A brownout reset clears the brownout flag; all other resets, power-on included, leave it.
// - A memory violation reset clears its flag; power-on or brownout sets it.
// - A memory violation reset is raised only for an executed fetch from an invalid area.
// - Stack events cause a reset and flag update only with the stack reset enable at 1.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rcp_regs
    import rcp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic [1:0] brownout_config_field,
    input wire logic stack_reset_enable,
    input wire logic brownout_circuit_ready_raw,
    input wire logic por_evt,
    input wire logic bor_evt,
    input wire logic ext_pin_rst_evt,
    input wire logic wdt_timeout_evt,
    input wire logic wdt_window_evt,
    input wire logic reset_instr_evt,
    input wire logic stack_ovf_evt,
    input wire logic stack_unf_evt,
    input wire logic instr_exec,
    input wire logic fetch_invalid,
    output logic brownout_enable,
    output logic core_reset_req,
    output logic irq
);
    logic ready_sync;
    logic soft_brownout_enable_r;
    logic [7:0] cause_r;
    logic [7:0] cause_nxt;
    logic memory_violation_flag_r;
    logic memory_violation_flag_nxt;
    logic [7:0] status_r;
    logic [7:0] mask_r;
    logic [7:0] events;
    logic pwr_rst;
    logic stk_ovf_go;
    logic stk_unf_go;
    logic memory_violation_flag_go;
    logic wr_borctl;
    logic wr_cause;
    logic wr_memory_violation_flag;
    logic wr_status;
    logic wr_mask;
    logic bor_en_nxt;
    logic circuit_ready;
    logic [7:0] rd_nxt;

    rcp_sync2 u_ready_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(brownout_circuit_ready_raw),
        .sync_out(ready_sync)
    );

    // Decoded qualifiers
    assign pwr_rst = por_evt | bor_evt;
    assign stk_ovf_go = stack_ovf_evt & stack_reset_enable;
    assign stk_unf_go = stack_unf_evt & stack_reset_enable;
    assign memory_violation_flag_go = instr_exec & fetch_invalid;
    assign wr_borctl = wr_en && (addr == RCP_OFS_BROWNOUT_CONTROL);
    assign wr_cause = wr_en && (addr == RCP_OFS_RESET_CAUSE_FLAGS);
    assign wr_memory_violation_flag = wr_en && (addr == RCP_OFS_MEMORY_VIOLATION_FLAGS);
    assign wr_status = wr_en && (addr == RCP_OFS_EVENT_STATUS);
    assign wr_mask = wr_en && (addr == RCP_OFS_EVENT_MASK);
    assign circuit_ready = ready_sync & brownout_enable;

    // Detection enable from config field
    always_comb begin
        if (brownout_config_field == RCP_CFG_SOFT) begin
            bor_en_nxt = soft_brownout_enable_r;
        end else if (brownout_config_field == RCP_CFG_OFF) begin
            bor_en_nxt = 1'b0;
        end else begin
            bor_en_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            brownout_enable <= 1'b0;
        end else begin
            brownout_enable <= bor_en_nxt;
        end
    end

    // Soft enable bit, reloaded on power-on or brownout
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            soft_brownout_enable_r <= RCP_RST_SOFT_BOR_EN;
        end else if (pwr_rst) begin
            soft_brownout_enable_r <= RCP_RST_SOFT_BOR_EN;
        end else if (wr_borctl) begin
            soft_brownout_enable_r <= wr_data[RCP_BIT_SOFT_BOR_EN];
        end
    end

    // Cause flags: hardware events beat firmware writes
    always_comb begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt = wr_data;
        end
        if (stk_ovf_go) begin
            cause_nxt[RCP_BIT_STK_OVF] = 1'b1;
        end
        if (stk_unf_go) begin
            cause_nxt[RCP_BIT_STK_UNF] = 1'b1;
        end
        if (wdt_window_evt) begin
            cause_nxt[RCP_BIT_WDT_WIN] = 1'b0;
        end
        if (wdt_timeout_evt) begin
            cause_nxt[RCP_BIT_WDT_TO] = 1'b0;
        end
        if (ext_pin_rst_evt) begin
            cause_nxt[RCP_BIT_PIN_RST] = 1'b0;
        end
        if (reset_instr_evt) begin
            cause_nxt[RCP_BIT_RST_INSTR] = 1'b0;
        end
        if (pwr_rst) begin
            cause_nxt[RCP_BIT_STK_OVF] = 1'b0;
            cause_nxt[RCP_BIT_STK_UNF] = 1'b0;
            cause_nxt[RCP_BIT_WDT_WIN] = 1'b1;
            cause_nxt[RCP_BIT_WDT_TO] = 1'b1;
            cause_nxt[RCP_BIT_PIN_RST] = 1'b1;
            cause_nxt[RCP_BIT_RST_INSTR] = 1'b1;
        end
        if (por_evt) begin
            cause_nxt[RCP_BIT_POR] = 1'b0;
        end
        if (bor_evt) begin
            cause_nxt[RCP_BIT_BOR] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cause_r <= RCP_RST_CAUSE_FLAGS;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // Memory violation flag
    always_comb begin
        memory_violation_flag_nxt = memory_violation_flag_r;
        if (wr_memory_violation_flag) begin
            memory_violation_flag_nxt = wr_data[RCP_BIT_MEMORY_VIOLATION_FLAG];
        end
        if (memory_violation_flag_go) begin
            memory_violation_flag_nxt = 1'b0;
        end
        if (pwr_rst) begin
            memory_violation_flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            memory_violation_flag_r <= RCP_RST_MEMORY_VIOLATION_FLAG;
        end else begin
            memory_violation_flag_r <= memory_violation_flag_nxt;
        end
    end

    // Reset request to the reset controller
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            core_reset_req <= 1'b0;
        end else begin
            core_reset_req <= memory_violation_flag_go | stk_ovf_go | stk_unf_go;
        end
    end

    // Sticky event status, set wins over write-one-to-clear
    assign events = {stk_ovf_go, stk_unf_go, wdt_window_evt, wdt_timeout_evt,
                     ext_pin_rst_evt, reset_instr_evt, bor_evt, memory_violation_flag_go};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_r <= RCP_RST_STATUS;
        end else if (wr_status) begin
            status_r <= (status_r & ~wr_data) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mask_r <= RCP_RST_MASK;
        end else if (wr_mask) begin
            mask_r <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // Read mux, data valid in the cycle after the strobe only
    always_comb begin
        rd_nxt = 8'h00;
        if (addr == RCP_OFS_BROWNOUT_CONTROL) begin
            rd_nxt[RCP_BIT_SOFT_BOR_EN] = soft_brownout_enable_r;
            rd_nxt[RCP_BIT_BOR_READY] = circuit_ready;
        end else if (addr == RCP_OFS_RESET_CAUSE_FLAGS) begin
            rd_nxt = cause_r;
        end else if (addr == RCP_OFS_MEMORY_VIOLATION_FLAGS) begin
            rd_nxt[RCP_BIT_MEMORY_VIOLATION_FLAG] = memory_violation_flag_r;
        end else if (addr == RCP_OFS_EVENT_STATUS) begin
            rd_nxt = status_r;
        end else if (addr == RCP_OFS_EVENT_MASK) begin
            rd_nxt = mask_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data <= RCP_RST_RD_DATA;
        end else if (rd_en) begin
            rd_data <= rd_nxt;
        end else begin
            rd_data <= RCP_RST_RD_DATA;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence memory_violation_flag_fault_s;
        instr_exec && fetch_invalid && !por_evt && !bor_evt;
    endsequence

    sequence memory_violation_flag_answer_s;
        !memory_violation_flag_r && core_reset_req;
    endsequence

    sequence ovf_gated_s;
        stack_ovf_evt && stack_reset_enable && !pwr_rst;
    endsequence

    sequence unf_gated_s;
        stack_unf_evt && stack_reset_enable && !pwr_rst;
    endsequence

    soft_bor_en_a:
    assert property ((brownout_config_field == RCP_CFG_SOFT) |=>
                     brownout_enable == $past(soft_brownout_enable_r))
        else $error("brownout enable does not follow soft enable");

    ready_read_a:
    assert property ((rd_en && addr == RCP_OFS_BROWNOUT_CONTROL) |=>
                     rd_data[RCP_BIT_BOR_READY] == $past(ready_sync & brownout_enable))
        else $error("ready bit read wrong");

    stk_ovf_set_a:
    assert property (ovf_gated_s |=> cause_r[RCP_BIT_STK_OVF] ##0 core_reset_req)
        else $error("stack overflow flag or reset missing");

    stk_gate_a:
    assert property ((stack_ovf_evt || stack_unf_evt) && !stack_reset_enable &&
                     !memory_violation_flag_go && !pwr_rst && !wr_cause |=>
                     !core_reset_req && $stable(cause_r[7:6]))
        else $error("stack event acted while disabled");

    pwr_flags_a:
    assert property (pwr_rst |=> cause_r[5:2] == 4'hF && cause_r[7:6] == 2'h0)
        else $error("power reset flag values wrong");

    wdt_clear_a:
    assert property ((wdt_timeout_evt || wdt_window_evt) && !pwr_rst |=>
                     !(cause_r[RCP_BIT_WDT_TO] && $past(wdt_timeout_evt)) &&
                     !(cause_r[RCP_BIT_WDT_WIN] && $past(wdt_window_evt)))
        else $error("watchdog flag not cleared");

    pin_instr_a:
    assert property ((ext_pin_rst_evt || reset_instr_evt) && !pwr_rst |=>
                     !(cause_r[RCP_BIT_PIN_RST] && $past(ext_pin_rst_evt)) &&
                     !(cause_r[RCP_BIT_RST_INSTR] && $past(reset_instr_evt)))
        else $error("pin or instruction flag not cleared");

    por_only_a:
    assert property (!por_evt && !wr_cause |=> $stable(cause_r[RCP_BIT_POR]))
        else $error("power-on flag changed without cause");

    bor_flag_a:
    assert property (bor_evt |=> !cause_r[RCP_BIT_BOR] && memory_violation_flag_r)
        else $error("brownout flag handling wrong");

    memory_violation_flag_seq_a:
    assert property (memory_violation_flag_fault_s |=> memory_violation_flag_answer_s)
        else $error("memory violation not answered");

    irq_level_a:
    assert property (##1 irq == $past(|(status_r & mask_r)))
        else $error("interrupt level wrong");

    stk_unf_set_a:
    assert property (unf_gated_s |=> cause_r[RCP_BIT_STK_UNF] ##0 core_reset_req)
        else $error("stack underflow flag or reset missing");

    pwr_reload_a:
    assert property (pwr_rst |=> memory_violation_flag_r && soft_brownout_enable_r)
        else $error("power reset reload wrong");

    por_clear_a:
    assert property (por_evt |=> !cause_r[RCP_BIT_POR])
        else $error("power-on flag not cleared");

    memory_violation_flag_rearm_a:
    assert property (wr_memory_violation_flag && wr_data[RCP_BIT_MEMORY_VIOLATION_FLAG] && !memory_violation_flag_go |=>
                     memory_violation_flag_r)
        else $error("memory violation flag not rearmed");

    status_set_a:
    assert property (events != 8'h00 |=> (status_r & $past(events)) == $past(events))
        else $error("event status bit not set");

    rd_idle_a:
    assert property (!rd_en |=> rd_data == RCP_RST_RD_DATA)
        else $error("read data not idle");
endmodule
`default_nettype wire

// ===== tb/rcp_src_model.sv
// Source model emitting single-cycle reset-cause pulses for the register bank
`timescale 1ns/1ns
`default_nettype none
module rcp_src_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [9:0] req,
    output logic por_evt,
    output logic bor_evt,
    output logic ext_pin_rst_evt,
    output logic wdt_timeout_evt,
    output logic wdt_window_evt,
    output logic reset_instr_evt,
    output logic stack_ovf_evt,
    output logic stack_unf_evt,
    output logic instr_exec,
    output logic fetch_invalid
);
    // Each request becomes one pulse one edge later
    always_ff @(posedge sys_clk) begin
        {fetch_invalid, instr_exec, stack_unf_evt, stack_ovf_evt, reset_instr_evt,
            wdt_window_evt, wdt_timeout_evt, ext_pin_rst_evt, bor_evt,
            por_evt} <= rst_n ? req : 10'h000;
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the power-control register bank
`timescale 1ns/1ns
`default_nettype none
module tb
    import rcp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    logic [1:0] brownout_config_field = RCP_CFG_SOFT;
    logic stack_reset_enable = 1'b0;
    logic brownout_circuit_ready_raw = 1'b1;
    logic [9:0] src_req = 10'h000;
    logic por_evt, bor_evt, ext_pin_rst_evt, wdt_timeout_evt, wdt_window_evt;
    logic reset_instr_evt, stack_ovf_evt, stack_unf_evt, instr_exec, fetch_invalid;
    logic brownout_enable, core_reset_req, irq;
    int n_mismatch = 0;
    int compares = 0;
    int n_req = 0;
    int cyc = 0;

    rcp_regs rcp_regs_inst (.sys_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .brownout_config_field, .stack_reset_enable, .brownout_circuit_ready_raw,
        .por_evt, .bor_evt, .ext_pin_rst_evt, .wdt_timeout_evt, .wdt_window_evt,
        .reset_instr_evt, .stack_ovf_evt, .stack_unf_evt, .instr_exec, .fetch_invalid,
        .brownout_enable, .core_reset_req, .irq);
    rcp_src_model rcp_src_model_inst (.sys_clk, .rst_n, .req(src_req), .por_evt,
        .bor_evt, .ext_pin_rst_evt, .wdt_timeout_evt, .wdt_window_evt,
        .reset_instr_evt, .stack_ovf_evt, .stack_unf_evt, .instr_exec, .fetch_invalid);

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic final_report;
        $display("Summary: %0d mismatches in %0d comparisons", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Reset request counter and run limit
    always @(posedge sys_clk) begin
        cyc++;
        if (rst_n && core_reset_req === 1'b1) begin
            n_req++;
        end
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input logic [7:0] exp, input logic [7:0] act);
        compares++;
        if (act !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        chk(exp, rd_data);
    endtask

    task automatic settle;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic fire(input logic [9:0] r);
        @(posedge sys_clk);
        src_req <= r;
        @(posedge sys_clk);
        src_req <= 10'h000;
        settle();
    endtask

    task automatic setcfg(input logic [1:0] c, input logic r);
        @(posedge sys_clk);
        brownout_config_field <= c;
        brownout_circuit_ready_raw <= r;
        settle();
    endtask

    task automatic t_reset;
        rdc(RCP_OFS_BROWNOUT_CONTROL, 8'h81);
        rdc(RCP_OFS_RESET_CAUSE_FLAGS, 8'h3C);
        rdc(RCP_OFS_MEMORY_VIOLATION_FLAGS, 8'h02);
        rdc(12'h812, 8'h00);
        chk(8'h01, {7'h00, brownout_enable});
    endtask

    task automatic t_causes;
        int fb[4] = '{3, 4, 5, 2};
        for (int i = 0; i < 4; i++) begin
            fire(10'h004 << i);
            rdc(RCP_OFS_RESET_CAUSE_FLAGS, 8'h3C & ~(8'h01 << fb[i]));
            wr(RCP_OFS_RESET_CAUSE_FLAGS, 8'h3C);
            rdc(RCP_OFS_RESET_CAUSE_FLAGS, 8'h3C);
        end
    endtask

    task automatic t_por_bor;
        for (int i = 0; i < 2; i++) begin
            wr(RCP_OFS_RESET_CAUSE_FLAGS, 8'hC3);
            wr(RCP_OFS_MEMORY_VIOLATION_FLAGS, 8'h00);
            wr(RCP_OFS_BROWNOUT_CONTROL, 8'h00);
            fire(10'h001 << i);
            rdc(RCP_OFS_RESET_CAUSE_FLAGS, (i == 0) ? 8'h3D : 8'h3E);
            rdc(RCP_OFS_MEMORY_VIOLATION_FLAGS, 8'h02);
            rdc(RCP_OFS_BROWNOUT_CONTROL, 8'h81);
        end
        wr(RCP_OFS_RESET_CAUSE_FLAGS, 8'h3C);
    endtask

    task automatic t_stack;
        int b;
        b = n_req;
        fire(10'h040);
        rdc(RCP_OFS_RESET_CAUSE_FLAGS, 8'h3C);
        @(posedge sys_clk);
        stack_reset_enable <= 1'b1;
        fire(10'h040);
        rdc(RCP_OFS_RESET_CAUSE_FLAGS, 8'hBC);
        fire(10'h080);
        rdc(RCP_OFS_RESET_CAUSE_FLAGS, 8'hFC);
        chk(8'(b + 2), 8'(n_req));
        wr(RCP_OFS_RESET_CAUSE_FLAGS, 8'h3C);
        rdc(RCP_OFS_RESET_CAUSE_FLAGS, 8'h3C);
    endtask

    task automatic t_memory_violation_flag;
        int b;
        b = n_req;
        fire(10'h200);
        fire(10'h100);
        rdc(RCP_OFS_MEMORY_VIOLATION_FLAGS, 8'h02);
        fire(10'h300);
        rdc(RCP_OFS_MEMORY_VIOLATION_FLAGS, 8'h00);
        chk(8'(b + 1), 8'(n_req));
        wr(RCP_OFS_MEMORY_VIOLATION_FLAGS, 8'h02);
        rdc(RCP_OFS_MEMORY_VIOLATION_FLAGS, 8'h02);
    endtask

    task automatic t_irq;
        wr(RCP_OFS_EVENT_STATUS, 8'hFF);
        rdc(RCP_OFS_EVENT_STATUS, 8'h00);
        fire(10'h004);
        rdc(RCP_OFS_EVENT_STATUS, 8'h08);
        chk(8'h00, {7'h00, irq});
        wr(RCP_OFS_EVENT_MASK, 8'h08);
        settle();
        chk(8'h01, {7'h00, irq});
        wr(RCP_OFS_EVENT_STATUS, 8'h08);
        settle();
        chk(8'h00, {7'h00, irq});
        rdc(RCP_OFS_EVENT_MASK, 8'h08);
    endtask

    task automatic t_bor_ctl;
        wr(RCP_OFS_BROWNOUT_CONTROL, 8'h01);
        settle();
        chk(8'h00, {7'h00, brownout_enable});
        rdc(RCP_OFS_BROWNOUT_CONTROL, 8'h00);
        setcfg(RCP_CFG_OFF, 1'b1);
        wr(RCP_OFS_BROWNOUT_CONTROL, 8'h80);
        settle();
        chk(8'h00, {7'h00, brownout_enable});
        rdc(RCP_OFS_BROWNOUT_CONTROL, 8'h80);
        setcfg(2'h2, 1'b1);
        chk(8'h01, {7'h00, brownout_enable});
        rdc(RCP_OFS_BROWNOUT_CONTROL, 8'h81);
        setcfg(2'h2, 1'b0);
        rdc(RCP_OFS_BROWNOUT_CONTROL, 8'h80);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle();
        t_reset();
        t_causes();
        t_por_bor();
        t_stack();
        t_memory_violation_flag();
        t_irq();
        t_bor_ctl();
        final_report();
    end
endmodule
`default_nettype wire
